/* verilog/eeprom_access_control.sv */
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control
  import nvm_access_pkg::*;
#(
  parameter int AW         = 9,
  parameter int FULL_TICKS = PROG_FULL_TICKS,
  parameter int HALF_TICKS = PROG_HALF_TICKS
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        GLOBAL_IRQ_EN,
  output logic             CORE_STALL,
  output logic             NVM_READY_IRQ
);
  nvm_mem_if #(.AW(AW), .DW(8)) mif ();

  nvm_byte_store #(.AW(AW), .DW(8)) u_store (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .port  (mif)
  );

  logic [AW-1:0] ptr_ff;
  logic [7:0]    dbuf_ff;
  logic [1:0]    mode_ff;
  logic          rie_ff;
  logic          arm_ff;
  logic [2:0]    arm_cnt_ff;
  logic          busy_ff;
  logic          rd_pend_ff;
  logic          rd_load_ff;
  logic          prog_rd_ff;
  logic [2:0]    stall_cnt_ff;
  logic [14:0]   tick_cnt_ff;
  logic [4:0]    div_cnt_ff;
  logic          rc_tick_ff;
  logic [AW-1:0] prog_ptr_ff;
  logic [7:0]    prog_data_ff;
  prog_action_t  prog_act_ff;
  logic          commit_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic [31:0]   prdata_ff;
  logic          stall_ff;
  logic          irq_ff;

  logic [9:0] idx;
  logic       hit;
  logic       ans_go;
  logic       wr_acc;
  logic       ctrl_wr;
  logic       rd_go;
  logic       prog_go;
  logic [7:0] ctrl_rd;
  logic [7:0] wbyte;
  logic [14:0] nxt_ticks;

  assign idx     = PADDR[11:2];
  assign hit     = (idx == IDX_CTRL) || (idx == IDX_DBUF) ||
                   (idx == IDX_PTR_LO) || (idx == IDX_PTR_HI);
  assign ans_go  = PSEL && !pready_ff && (stall_cnt_ff == 3'h0);
  assign wbyte   = PWDATA[7:0];
  assign wr_acc  = PSEL && PENABLE && pready_ff && PWRITE && PSTRB[0] && hit;
  assign ctrl_wr = wr_acc && (idx == IDX_CTRL);
  assign rd_go   = ctrl_wr && wbyte[BIT_RD] && !busy_ff;
  assign prog_go = ctrl_wr && wbyte[BIT_WR] && arm_ff && !busy_ff
                   && (prog_action_t'(mode_ff) != ACT_RSVD);
  assign nxt_ticks = (prog_action_t'(mode_ff) == ACT_ATOMIC)
                   ? 15'(FULL_TICKS) : 15'(HALF_TICKS);
  assign ctrl_rd = {2'h0, mode_ff, rie_ff, arm_ff, busy_ff, rd_pend_ff};

  // APB slave: one wait-free access unless a read stall is running
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= ans_go;
      pslverr_ff <= ans_go && !hit;
      if (ans_go && !PWRITE) begin
        case (idx)
          IDX_CTRL:   prdata_ff <= {24'h000000, ctrl_rd};
          IDX_DBUF:   prdata_ff <= {24'h000000, dbuf_ff};
          IDX_PTR_LO: prdata_ff <= {24'h000000, 8'(ptr_ff)};
          IDX_PTR_HI: prdata_ff <= {31'h00000000, ptr_ff[AW-1]};
          default:    prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Location pointer, locked while programming
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_ff <= '0;
    end else if (wr_acc && !busy_ff) begin
      if (idx == IDX_PTR_LO) begin
        ptr_ff[7:0] <= wbyte;
      end else if (idx == IDX_PTR_HI) begin
        ptr_ff[AW-1] <= wbyte[0];
      end
    end
  end

  // Byte buffer: software writes, read results
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dbuf_ff <= 8'h00;
    end else if (rd_load_ff) begin
      dbuf_ff <= mif.rdata;
    end else if (wr_acc && idx == IDX_DBUF) begin
      dbuf_ff <= wbyte;
    end
  end

  // Mode and ready enable
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_ff <= MODE_RESET;
      rie_ff  <= 1'b0;
    end else if (ctrl_wr) begin
      rie_ff <= wbyte[BIT_RIE];
      if (!busy_ff) begin
        mode_ff <= {wbyte[BIT_MODE1], wbyte[BIT_MODE0]};
      end
    end
  end

  // Write arm window
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      arm_ff     <= 1'b0;
      arm_cnt_ff <= 3'h0;
    end else if (prog_go) begin
      arm_ff     <= 1'b0;
      arm_cnt_ff <= 3'h0;
    end else if (ctrl_wr && wbyte[BIT_ARM] && !arm_ff) begin
      arm_ff     <= 1'b1;
      arm_cnt_ff <= ARM_WINDOW_CYC;
    end else if (arm_ff) begin
      if (arm_cnt_ff == 3'h1) begin
        arm_ff <= 1'b0;
      end
      arm_cnt_ff <= arm_cnt_ff - 3'h1;
    end
  end

  // Read sequencing and core stall
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_pend_ff   <= 1'b0;
      rd_load_ff   <= 1'b0;
      stall_cnt_ff <= 3'h0;
      stall_ff     <= 1'b0;
    end else begin
      rd_pend_ff <= rd_go;
      rd_load_ff <= rd_pend_ff;
      if (rd_go) begin
        stall_cnt_ff <= READ_STALL_CYC;
        stall_ff     <= 1'b1;
      end else if (stall_cnt_ff != 3'h0) begin
        stall_cnt_ff <= stall_cnt_ff - 3'h1;
        stall_ff     <= (stall_cnt_ff != 3'h1);
      end
    end
  end

  // RC oscillator rate enable
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_cnt_ff <= 5'h00;
      rc_tick_ff <= 1'b0;
    end else begin
      rc_tick_ff <= (div_cnt_ff == 5'(RC_DIV - 1));
      if (div_cnt_ff == 5'(RC_DIV - 1)) begin
        div_cnt_ff <= 5'h00;
      end else begin
        div_cnt_ff <= div_cnt_ff + 5'h01;
      end
    end
  end

  // Programming timer and latched operands
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_ff      <= 1'b0;
      tick_cnt_ff  <= 15'h0000;
      prog_ptr_ff  <= '0;
      prog_data_ff <= 8'h00;
      prog_act_ff  <= ACT_ATOMIC;
      prog_rd_ff   <= 1'b0;
      commit_ff    <= 1'b0;
    end else begin
      prog_rd_ff <= prog_go;
      commit_ff  <= 1'b0;
      if (prog_go) begin
        busy_ff      <= 1'b1;
        tick_cnt_ff  <= nxt_ticks;
        prog_ptr_ff  <= ptr_ff;
        prog_data_ff <= dbuf_ff;
        prog_act_ff  <= prog_action_t'(mode_ff);
      end else if (busy_ff && rc_tick_ff) begin
        if (tick_cnt_ff == 15'h0001) begin
          busy_ff   <= 1'b0;
          commit_ff <= 1'b1;
        end
        tick_cnt_ff <= tick_cnt_ff - 15'h0001;
      end
    end
  end

  always_comb begin
    mif.addr  = busy_ff || commit_ff ? prog_ptr_ff : ptr_ff;
    mif.re    = rd_pend_ff || prog_rd_ff;
    mif.we    = commit_ff;
    case (prog_act_ff)
      ACT_ERASE: mif.wdata = ERASED_BYTE;
      ACT_WRITE: mif.wdata = mif.rdata & prog_data_ff;
      default:   mif.wdata = prog_data_ff;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= rie_ff && GLOBAL_IRQ_EN && !busy_ff;
    end
  end

  assign PRDATA        = prdata_ff;
  assign PREADY        = pready_ff;
  assign PSLVERR       = pslverr_ff;
  assign CORE_STALL    = stall_ff;
  assign NVM_READY_IRQ = irq_ff;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence read_taken_s;
    rd_go;
  endsequence
  sequence stall_run_s;
    CORE_STALL [*4] ##1 !CORE_STALL;
  endsequence

  read_stall_a: assert property (read_taken_s |=> stall_run_s)
    else $error("read stall length wrong");
  read_data_a: assert property (rd_go |=> ##2 (dbuf_ff == $past(mif.rdata)))
    else $error("read byte not in buffer");
  strobe_clear_a: assert property (rd_go |=> rd_pend_ff ##1 !rd_pend_ff)
    else $error("read strobe did not clear");
  busy_no_read_a: assert property (busy_ff |-> !rd_pend_ff ##0 !rd_go)
    else $error("read taken while busy");
  ptr_locked_a: assert property (busy_ff ##1 busy_ff |-> $stable(ptr_ff))
    else $error("pointer moved while busy");
  arm_timeout_a: assert property ($rose(arm_ff) |-> ##4 !arm_ff)
    else $error("arm window not four cycles");
  arm_needed_a: assert property ($rose(busy_ff) |-> $past(arm_ff))
    else $error("program started unarmed");
  prog_time_a: assert property (prog_go |=> tick_cnt_ff == nxt_ticks
                                 ##0 busy_ff)
    else $error("program time not loaded");
  busy_end_a: assert property (busy_ff && rc_tick_ff &&
                               tick_cnt_ff == 15'h0001 |=> !busy_ff ##0
                               mif.we)
    else $error("busy not cleared at end");
  ready_irq_a: assert property (##1 NVM_READY_IRQ ==
                 $past(rie_ff && GLOBAL_IRQ_EN && !busy_ff))
    else $error("ready interrupt mismatch");
  hold_data_a: assert property (busy_ff ##1 busy_ff |->
                 $stable(prog_data_ff) && $stable(prog_ptr_ff))
    else $error("latched operands changed");
endmodule : eeprom_access_control
`default_nettype wire

/* verilog/nvm_access_pkg.sv */
//Contract
//- Read strobe bit 0 starts byte read
//- Read data ready for next instruction
//- Read stalls core four cycles
//- Busy blocks reads and pointer writes
//- Atomic programming takes 26368 RC oscillator cycles; erase or write alone takes 14400
//- Strobe accepted within four cycles; arm self-clears
//- Hardware clears write strobe when done
//- Mode bits select erase, write, or both
//- Ready interrupt while write strobe clear
package nvm_access_pkg;
  localparam logic [9:0] IDX_CTRL   = 10'h01F;
  localparam logic [9:0] IDX_DBUF   = 10'h020;
  localparam logic [9:0] IDX_PTR_LO = 10'h021;
  localparam logic [9:0] IDX_PTR_HI = 10'h022;
  localparam int BIT_RD    = 0;
  localparam int BIT_WR    = 1;
  localparam int BIT_ARM   = 2;
  localparam int BIT_RIE   = 3;
  localparam int BIT_MODE0 = 4;
  localparam int BIT_MODE1 = 5;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int CORE_HZ = 200000000;
  localparam int RC_HZ   = 8000000;
  localparam int RC_DIV  = CORE_HZ / RC_HZ;
  localparam int PROG_FULL_TICKS = 26368;
  localparam int PROG_HALF_US    = 1800;
  localparam int PROG_HALF_TICKS = PROG_HALF_US * (RC_HZ / 1000000);
  localparam logic [2:0] READ_STALL_CYC = 3'h4;
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  typedef enum logic [1:0] {
    ACT_ATOMIC, ACT_ERASE, ACT_WRITE, ACT_RSVD
  } prog_action_t;
endpackage : nvm_access_pkg

/* verilog/nvm_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface nvm_mem_if #(parameter int AW = 9, parameter int DW = 8);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          we;
  logic          re;
  logic [DW-1:0] rdata;
  modport ctrl (output addr, wdata, we, re, input rdata);
  modport mem  (input addr, wdata, we, re, output rdata);
endinterface : nvm_mem_if
`default_nettype wire

/* verilog/nvm_byte_store.sv */
`timescale 1ns/1ps
`default_nettype none
module nvm_byte_store #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  nvm_mem_if.mem    port
);
  logic [DW-1:0] cells [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge clk) begin
    if (port.we) begin
      cells[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (port.re) begin
      rdata_ff <= cells[port.addr];
    end
  end

  assign port.rdata = rdata_ff;
endmodule : nvm_byte_store
`default_nettype wire

/* dv/eeprom_access_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control_bench
  import nvm_access_pkg::*;
;
  localparam int FT = 4;
  localparam int HT = 2;
  logic        ref_clk = 1'b0;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        gie;
  logic        core_stall;
  logic        rdy_irq;
  int          failures = 0;
  int          n_tests  = 0;
  int          stall_n  = 0;
  int          cyc      = 0;
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  logic [31:0] lfsr_st;
  logic [31:0] rd_last;

  always #2.5 ref_clk = ~ref_clk;

  eeprom_access_control #(.FULL_TICKS(FT), .HALF_TICKS(HT)) dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .GLOBAL_IRQ_EN(gie), .CORE_STALL(core_stall), .NVM_READY_IRQ(rdy_irq)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic rnd(output logic [7:0] v);
    lfsr_st = lfsr_next(lfsr_st);
    v = lfsr_st[7:0];
  endtask : rnd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Cycle and stall counters
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (core_stall === 1'b1) stall_n <= stall_n + 1;
  end

  // Oldest note against each completed transfer
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      mon_e = exp_q.pop_front();
      if (mon_e[33]) check(prdata, mon_e[31:0]);
      check({31'h0, pslverr}, {31'h0, mon_e[32]});
    end
  end

  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [7:0] d, input logic [33:0] e);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    pstrb  <= w ? 4'hF : 4'h0;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    exp_q.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 200) failures++;
    rd_last = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Poll the busy bit until programming is over
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      xfer(1'b0, IDX_CTRL, 8'h00, 34'h0);
      k++;
    end while (rd_last[1] !== 1'b0 && k < 100);
  endtask : wait_idle

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 34'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] x);
    xfer(1'b0, idx, 8'h00, {2'b10, 24'h0, x});
  endtask : rd

  task automatic eread(input logic [8:0] p, input logic [7:0] x);
    int s0;
    wait_idle();
    wr(IDX_PTR_HI, {7'h0, p[8]});
    wr(IDX_PTR_LO, p[7:0]);
    s0 = stall_n;
    wr(IDX_CTRL, 8'h01);
    rd(IDX_DBUF, x);
    check(32'(stall_n - s0), 32'h4);
    rd(IDX_CTRL, 8'h00);
  endtask : eread

  task automatic eprog(input logic [1:0] m, input logic [8:0] p,
                       input logic [7:0] d, input int n);
    int t0;
    int s0;
    wait_idle();
    wr(IDX_PTR_HI, {7'h0, p[8]});
    wr(IDX_PTR_LO, p[7:0]);
    wr(IDX_DBUF, d);
    wr(IDX_CTRL, {2'b00, m, 4'hC});
    wr(IDX_CTRL, {2'b00, m, 4'hE});
    t0 = cyc;
    repeat (3) @(negedge ref_clk);
    check({31'h0, rdy_irq}, {31'h0, m == 2'b11});
    if (m != 2'b11) begin
      wr(IDX_PTR_LO, ~p[7:0]);
      wr(IDX_DBUF, ~d);
      s0 = stall_n;
      wr(IDX_CTRL, {2'b00, m ^ 2'b01, 4'h9});
      rd(IDX_CTRL, {2'b00, m, 4'hA});
      check(32'(stall_n - s0), 32'h0);
      do xfer(1'b0, IDX_CTRL, 8'h00, 34'h0);
      while (rd_last[1] !== 1'b0 && cyc - t0 < 400);
      check({31'h0, cyc - t0 >= (n - 1) * RC_DIV &&
             cyc - t0 <= n * RC_DIV + 8}, 32'h1);
      repeat (3) @(negedge ref_clk);
      check({31'h0, rdy_irq}, 32'h1);
      rd(IDX_PTR_LO, p[7:0]);
    end else begin
      rd(IDX_CTRL, {2'b00, m, 4'h8});
    end
  endtask : eprog

  initial begin
    logic [7:0] a;
    logic [7:0] d1;
    logic [7:0] d2;
    reset_n = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
    gie     = 1'b1;
    lfsr_st = 32'hDACA;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(IDX_CTRL + 10'(i), 8'h00);
    xfer(1'b0, 10'h000, 8'h00, {2'b01, 32'h0});
    xfer(1'b1, 10'h3FF, 8'h5A, {2'b01, 32'h0});
    rnd(a);
    rnd(d1);
    rnd(d2);
    eprog(2'b00, {1'b1, a}, d1, FT);
    eread({1'b1, a}, d1);
    eprog(2'b10, {1'b1, a}, d2, HT);
    eread({1'b1, a}, d1 & d2);
    eprog(2'b01, {1'b1, a}, d2, HT);
    eread({1'b1, a}, ERASED_BYTE);
    eprog(2'b11, {1'b1, a}, d1, 0);
    eread({1'b1, a}, ERASED_BYTE);
    // Strobe after the arm window has run out
    wr(IDX_CTRL, 8'h04);
    repeat (6) @(posedge ref_clk);
    wr(IDX_CTRL, 8'h02);
    rd(IDX_CTRL, 8'h00);
    gie <= 1'b0;
    wr(IDX_CTRL, 8'h08);
    repeat (3) @(negedge ref_clk);
    check({31'h0, rdy_irq}, 32'h0);
    test_done;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    test_done;
  end
endmodule : eeprom_access_control_bench
`default_nettype wire
